// *** fte_pkg.sv ***
package fte_pkg;

    // code-group width and nibble width
    localparam int CG_W = 5;
    localparam int NIB_W = 4;

    // line control code-groups
    localparam logic [4:0] CG_IDLE = 5'h1f;   // 11111
    localparam logic [4:0] CG_J = 5'h18;      // 11000
    localparam logic [4:0] CG_K = 5'h11;      // 10001
    localparam logic [4:0] CG_T = 5'h0d;      // 01101
    localparam logic [4:0] CG_R = 5'h07;      // 00111
    localparam logic [4:0] CG_HALT = 5'h04;   // 00100

    // bit counter within one code-group
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h4;

    // scrambler layout: 11 stages, taps at x^11 and x^9
    localparam int SCR_W = 11;
    localparam int SCR_TAP_HI = 10;
    localparam int SCR_TAP_LO = 8;
    localparam logic [6:0] SCR_SEED_LOW = 7'h55;  // low seed bits, keeps seed nonzero
    localparam logic [10:0] SCR_ZERO = 11'h000;

    // mlt-3 phases: zero, plus, zero, minus
    localparam logic [1:0] MLT_PLUS = 2'h1;
    localparam logic [1:0] MLT_MINUS = 2'h3;
    localparam logic [1:0] MLT_STEP = 2'h1;

    // fifo depth in nibbles
    localparam int FIFO_DEPTH = 4;

    // one mii transmit nibble with its qualifiers
    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] data;
    } fte_nib_s;

    localparam int NIB_S_W = 6;

    // encoder sequencing states
    typedef enum logic [1:0] {
        FTE_IDLE,
        FTE_SEND_K,
        FTE_DATA,
        FTE_SEND_R
    } fte_state_e;

    // 4b to 5b data table
    function automatic logic [4:0] fte_enc4b5b(input logic [3:0] nib);
        logic [4:0] cg;
        cg = CG_HALT;
        case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
            default: cg = CG_HALT;
        endcase
        return cg;
    endfunction

endpackage

// *** fte_fifo.sv ***
`timescale 1ns/1ps

module fte_fifo
    import fte_pkg::*;
#(
    parameter int WIDTH = NIB_S_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////////
    // handshakes: ready and valid are registered flags
    assign push = i_ce && i_in_valid && o_in_ready;
    assign pop = i_ce && o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_ptr_reg];

    // occupancy after this cycle
    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + CW'(1);
        else if (pop && !push)
            count_next = count_reg - CW'(1);
    end

    // storage
    always_ff @(posedge i_core_clk)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= i_in_data;
    end

    // pointers, count and flags
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
        end
        else if (i_ce)
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + AW'(1);
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + AW'(1);
            count_reg <= count_next;
            o_in_ready <= (count_next != CNT_FULL); // honest full
            o_out_valid <= (count_next != '0);      // honest empty
        end
    end

endmodule

// *** fte_tx_encoder.sv ***
`timescale 1ns/1ps

module fte_tx_encoder
    import fte_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_nib_valid,
    output logic o_nib_ready,
    input wire logic i_tx_en,
    input wire logic i_tx_er,
    input wire logic [3:0] i_txd,
    input wire logic [4:0] i_phy_address_straps,
    input wire logic i_scr_bypass,
    output logic o_mlt_pos,
    output logic o_mlt_neg,
    output logic o_nrzi
);

    fte_nib_s in_nib;
    fte_nib_s head;
    logic head_valid;
    logic head_pop;
    logic load;
    logic [4:0] cg_sel;
    logic pop_sel;
    fte_state_e state_reg;
    fte_state_e state_next;
    logic [2:0] bit_cnt_reg;
    logic [4:0] shift_reg;
    logic nrz_bit;
    logic [SCR_W-1:0] scr_reg;
    logic scr_key;
    logic line_bit;
    logic [1:0] mlt_phase_reg;
    logic [1:0] mlt_phase_next;

    ////////////////////////////////////////////////////////////////////////////////
    // nibble buffer between mii and encoder

    assign in_nib = '{en: i_tx_en, er: i_tx_er, data: i_txd};

    fte_fifo #(
        .WIDTH(NIB_S_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(i_nib_valid),
        .o_in_ready(o_nib_ready),
        .i_in_data(in_nib),
        .o_out_valid(head_valid),
        .i_out_ready(head_pop),
        .o_out_data(head)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // code-group selection and sequencing

    assign load = (bit_cnt_reg == BIT_FIRST);
    assign head_pop = load && pop_sel;

    // choose next code-group and whether the head nibble is consumed
    always_comb
    begin
        cg_sel = CG_IDLE;
        pop_sel = 1'b0;
        state_next = state_reg;
        case (state_reg)
            FTE_IDLE:
            begin
                cg_sel = CG_IDLE;
                if (head_valid && head.en)
                begin
                    cg_sel = CG_J;
                    pop_sel = 1'b1;
                    state_next = FTE_SEND_K;
                end
                else if (head_valid)
                    pop_sel = 1'b1; // stray idle nibble dropped
            end
            FTE_SEND_K:
            begin
                cg_sel = CG_K;
                pop_sel = head_valid && head.en;
                state_next = FTE_DATA;
            end
            FTE_DATA:
            begin
                if (head_valid && head.en)
                begin
                    cg_sel = head.er ? CG_HALT : fte_enc4b5b(head.data);
                    pop_sel = 1'b1;
                end
                else if (head_valid)
                begin
                    cg_sel = CG_T;
                    pop_sel = 1'b1;
                    state_next = FTE_SEND_R;
                end
                else
                    cg_sel = CG_HALT; // underrun marks the frame as errored
            end
            FTE_SEND_R:
            begin
                cg_sel = CG_R;
                state_next = FTE_IDLE;
            end
            default:
            begin
                cg_sel = CG_IDLE;
                state_next = FTE_IDLE;
            end
        endcase
    end

    // state advances once per code-group
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            state_reg <= FTE_IDLE;
        else if (i_ce && load)
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serializer, msb of each code-group first

    assign nrz_bit = load ? cg_sel[4] : shift_reg[4];

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            bit_cnt_reg <= BIT_FIRST;
            shift_reg <= CG_IDLE;
        end
        else if (i_ce)
        begin
            bit_cnt_reg <= (bit_cnt_reg == BIT_LAST) ? BIT_FIRST : bit_cnt_reg + 3'h1;
            shift_reg <= load ? {cg_sel[3:0], 1'b0} : {shift_reg[3:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scrambler

    assign scr_key = scr_reg[SCR_TAP_HI] ^ scr_reg[SCR_TAP_LO];
    assign line_bit = i_scr_bypass ? nrz_bit : (nrz_bit ^ scr_key);

    // lfsr free runs; seed is from straps 4:1, so ports differing only in strap bit 0 share it
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            scr_reg <= {i_phy_address_straps[4:1], SCR_SEED_LOW};
        else if (i_ce)
            scr_reg <= {scr_reg[SCR_W-2:0], scr_key};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // nrzi and mlt-3 drive phases

    assign mlt_phase_next = line_bit ? mlt_phase_reg + MLT_STEP : mlt_phase_reg;

    // nrzi level toggles per one
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            o_nrzi <= 1'b0;
        else if (i_ce)
            o_nrzi <= o_nrzi ^ line_bit;
    end

    // each one steps the phase, so ones drive pos, zero, neg, zero in turn
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            mlt_phase_reg <= '0;
            o_mlt_pos <= 1'b0;
            o_mlt_neg <= 1'b0;
        end
        else if (i_ce)
        begin
            mlt_phase_reg <= mlt_phase_next;
            o_mlt_pos <= (mlt_phase_next == MLT_PLUS);
            o_mlt_neg <= (mlt_phase_next == MLT_MINUS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_idle_fill;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_reg == FTE_IDLE && load && !head_valid) |-> cg_sel == CG_IDLE;
    endproperty
    a_idle_fill: assert property (p_idle_fill)
        else $error("idle gap not filled with idle code");

    property p_jk_pair;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && load && cg_sel == CG_J) ##1 (i_ce [*4]) ##1 (i_ce && load) |->
            cg_sel == CG_K;
    endproperty
    a_jk_pair: assert property (p_jk_pair)
        else $error("start delimiter J not followed by K");

    property p_tr_pair;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && load && state_reg == FTE_DATA && cg_sel == CG_T) ##1 (i_ce [*4])
            ##1 (i_ce && load) |-> cg_sel == CG_R;
    endproperty
    a_tr_pair: assert property (p_tr_pair)
        else $error("end delimiter T not followed by R");

    property p_data_map;
        @(posedge i_core_clk) disable iff (i_rst)
        (load && state_reg == FTE_DATA && head_valid && head.en && !head.er) |->
            (cg_sel != CG_HALT && cg_sel == fte_enc4b5b(head.data));
    endproperty
    a_data_map: assert property (p_data_map)
        else $error("data nibble encoded to wrong code-group");

    property p_lfsr_live;
        @(posedge i_core_clk) disable iff (i_rst)
        1'b1 |-> scr_reg != SCR_ZERO;
    endproperty
    a_lfsr_live: assert property (p_lfsr_live)
        else $error("scrambler reached all zero");

    property p_bypass;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && i_scr_bypass) |=> o_nrzi == ($past(o_nrzi) ^ $past(nrz_bit));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass did not pass encoded stream");

    property p_scramble;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && !i_scr_bypass) |=>
            o_nrzi == ($past(o_nrzi) ^ $past(nrz_bit) ^ $past(scr_key));
    endproperty
    a_scramble: assert property (p_scramble)
        else $error("line bit not scrambled nrz");

    property p_mlt_exclusive;
        @(posedge i_core_clk) disable iff (i_rst)
        1'b1 |-> !(o_mlt_pos && o_mlt_neg);
    endproperty
    a_mlt_exclusive: assert property (p_mlt_exclusive)
        else $error("both mlt-3 streams active");

    property p_mlt_alternate;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && o_mlt_pos) ##1 (i_ce && !o_mlt_pos && !o_mlt_neg) ##1 i_ce |->
            !o_mlt_pos;
    endproperty
    a_mlt_alternate: assert property (p_mlt_alternate)
        else $error("mlt-3 pos phase repeated without neg");

    property p_nrzi_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !i_ce |=> $stable(o_nrzi) && $stable(o_mlt_pos) && $stable(o_mlt_neg);
    endproperty
    a_nrzi_hold: assert property (p_nrzi_hold)
        else $error("line state moved while clock enable low");

    property p_seed;
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(i_rst) |-> scr_reg == {i_phy_address_straps[4:1], SCR_SEED_LOW};
    endproperty
    a_seed: assert property (p_seed)
        else $error("scrambler seed not taken from the straps");

    property p_err_halt;
        @(posedge i_core_clk) disable iff (i_rst)
        (load && state_reg == FTE_DATA && head_valid && head.en && head.er) |-> cg_sel == CG_HALT;
    endproperty
    a_err_halt: assert property (p_err_halt)
        else $error("errored nibble not sent as halt");

endmodule

// *** fte_mac_model.sv ***
`timescale 1ns/1ps

// mac side of the mii transmit path: offers one nibble, holds it until taken
module fte_mac_model
    import fte_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_ready,
    output logic o_valid,
    output logic o_tx_en,
    output logic o_tx_er,
    output logic [3:0] o_txd
);
    int n_stall = 0;
    int n_timeout = 0;  // offers that were never taken

    // bus idle at time zero
    initial
    begin
        o_valid = 1'b0;
        o_tx_en = 1'b0;
        o_tx_er = 1'b0;
        o_txd = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // caller enters just after an edge; nibble held until ready is sampled
    task automatic send(input logic en, input logic er, input logic [3:0] d);
        int guard;
        guard = 0;
        o_valid = 1'b1;
        o_tx_en = en;
        o_tx_er = er;
        o_txd = d;
        @(posedge i_core_clk);
        while (i_ready !== 1'b1 && guard < 200)
        begin
            n_stall++;
            guard++;
            @(posedge i_core_clk);
        end
        if (guard >= 200)
            n_timeout++;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // drop the strobe; stale qualifiers are inverted so nothing leans on them
    task automatic release_bus();
        o_valid = 1'b0;
        o_tx_en = ~o_tx_en;
        o_tx_er = ~o_tx_er;
        o_txd = ~o_txd;
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps

module testbench;
    import fte_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_scr_bypass = 1'b1;
    logic [4:0] straps = 5'h00;
    logic valid, en, er, ready, pos, neg, nrzi;
    logic [3:0] txd;
    int n_mismatch = 0;
    int n_compared = 0;
    logic bits[$];
    logic keys[$];
    logic [10:0] scr;
    logic ce_d = 1'b0;
    logic nrzi_d;
    logic [1:0] ph;
    localparam logic [4:0] TBL [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    fte_mac_model mac (.i_core_clk(i_core_clk), .i_ready(ready), .o_valid(valid),
        .o_tx_en(en), .o_tx_er(er), .o_txd(txd));

    fte_tx_encoder dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_nib_valid(valid), .o_nib_ready(ready), .i_tx_en(en), .i_tx_er(er),
        .i_txd(txd), .i_phy_address_straps(straps), .i_scr_bypass(i_scr_bypass),
        .o_mlt_pos(pos), .o_mlt_neg(neg), .o_nrzi(nrzi));

    // 100 mhz core clock
    always #5 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // recover line bits from nrzi edges, run a reference lfsr, track mlt phase
    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            scr = {straps[4:1], SCR_SEED_LOW};
            ph = 2'h0;
            nrzi_d = 1'b0;
        end
        else if (ce_d)
        begin
            bits.push_back(nrzi ^ nrzi_d);
            keys.push_back(scr[10] ^ scr[8]);
            scr = {scr[9:0], scr[10] ^ scr[8]};
            if (nrzi !== nrzi_d)
                ph = ph + 2'h1;
            chk(pos, ph == 2'h1);
            chk(neg, ph == 2'h3);
            nrzi_d = nrzi;
        end
        ce_d = i_ce;
    end

    // search the recovered stream for code-groups sent msb first
    function automatic bit seq_found(logic [4:0] cg[$]);
        logic p[$];
        int lag, i, k;
        bit hit;
        foreach (cg[j])
            for (k = 4; k >= 0; k--)
                p.push_back(cg[j][k]);
        for (lag = -2; lag <= 3; lag++)
            for (i = 3; i + p.size() + 2 <= bits.size(); i++)
            begin
                hit = 1;
                for (k = 0; k < p.size() && hit; k++)
                    if ((bits[i+k] ^ (i_scr_bypass ? 1'b0 : keys[i+k-lag])) !== p[k])
                        hit = 0;
                if (hit)
                    return 1;
            end
        return 0;
    endfunction

    task automatic do_reset(input logic [4:0] s, input logic byp);
        int guard;
        guard = 0;
        i_rst = 1'b1;
        straps = s;
        i_scr_bypass = byp;
        repeat (6) @(posedge i_core_clk);
        #1;
        chk({pos, neg, nrzi, ready}, 5'h00);
        i_rst = 1'b0;
        while (ready !== 1'b1 && guard < 5)
        begin
            @(posedge i_core_clk);
            #1;
            guard++;
        end
        chk(ready, 1'b1);
        bits.delete();
        keys.delete();
    endtask

    // preamble pair, body nibbles, one closing nibble; optional error or stall
    task automatic frame(input logic [3:0] d[$], input int er_at, input int gap_at);
        mac.send(1'b1, 1'b0, 4'h5);
        mac.send(1'b1, 1'b0, 4'h5);
        foreach (d[j])
        begin
            if (j == gap_at)
            begin
                mac.release_bus();
                repeat (40) @(posedge i_core_clk);
                #1;
            end
            mac.send(1'b1, j == er_at, d[j]);
        end
        mac.send(1'b0, 1'b0, 4'h0);
        mac.release_bus();
        repeat (5 * d.size() + 80) @(posedge i_core_clk);
        #1;
        chk(mac.n_timeout != 0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every nibble value in one unscrambled frame; fifo fills and refuses
    task automatic t_data();
        logic [3:0] d[$];
        logic [4:0] q[$];
        q = {5'h18, 5'h11};
        for (int i = 0; i < 16; i++)
        begin
            d.push_back(i[3:0]);
            q.push_back(TBL[i]);
        end
        q = {q, 5'h0d, 5'h07, 5'h1f, 5'h1f, 5'h1f};
        do_reset(5'h00, 1'b1);
        frame(d, -1, -1);
        chk(seq_found(q), 1'b1);
        chk(mac.n_stall > 0, 1'b1);
    endtask

    // scrambled frames under two strap settings
    task automatic t_scr();
        logic [4:0] s[2];
        logic [4:0] q[$];
        s = '{5'h1e, 5'h0b};
        for (int n = 0; n < 2; n++)
        begin
            do_reset(s[n], 1'b0);
            frame('{4'h3, 4'hc, 4'h9}, -1, -1);
            q = {5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f};
            chk(seq_found(q), 1'b1);
            q = {5'h18, 5'h11, 5'h15, 5'h1a, 5'h13, 5'h0d, 5'h07, 5'h1f};
            chk(seq_found(q), 1'b1);
        end
    endtask

    // error nibble and mid-frame underrun both show as halt
    task automatic t_halt();
        do_reset(5'h00, 1'b1);
        frame('{4'h1, 4'h2, 4'h3}, 1, -1);
        chk(seq_found('{5'h09, 5'h04, 5'h15}), 1'b1);
        frame('{4'h7, 4'h8}, -1, 1);
        chk(seq_found('{5'h0f, 5'h04}), 1'b1);
        chk(seq_found('{5'h12, 5'h0d, 5'h07}), 1'b1);
    endtask

    // clock enable low freezes the line outputs
    task automatic t_ce();
        logic [2:0] held;
        repeat (3) @(posedge i_core_clk);
        #1;
        i_ce = 1'b0;
        @(posedge i_core_clk);
        #1;
        held = {pos, neg, nrzi};
        repeat (8)
        begin
            @(posedge i_core_clk);
            #1;
            chk({pos, neg, nrzi}, held);
        end
        i_ce = 1'b1;
    endtask

    // watchdog for a hung run
    initial
    begin
        #500000;
        n_mismatch++;
        end_sim();
    end

    // main sequence
    initial
    begin
        t_data();
        t_scr();
        t_halt();
        t_ce();
        end_sim();
    end
endmodule
